// ---- hdl/dms_regs.svh ----
// Register offsets, field positions, reset values and flag bit positions of the arithmetic slice.
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH
`define DMS_OFS_CFG    12'h000
`define DMS_OFS_PAT    12'h004
`define DMS_OFS_MASK   12'h008
`define DMS_OFS_STAT   12'h00c
`define DMS_OFS_RESLO  12'h010
`define DMS_OFS_RESHI  12'h014
`define DMS_CFG_ELEM   2:0
`define DMS_CFG_WID    4:3
`define DMS_CFG_SGN    5
`define DMS_CFG_INREG  6
`define DMS_CFG_PPREG  7
`define DMS_CFG_OUTREG 8
`define DMS_CFG_ASYNC  9
`define DMS_CFG_CSEL   11:10
`define DMS_CFG_SELIN  13:12
`define DMS_CFG_SELPP  15:14
`define DMS_CFG_SELOUT 17:16
`define DMS_CFG_RST    18'h001e8
`define DMS_PAT_RST    32'h0000_0000
`define DMS_MASK_RST   32'h0000_0000
`define DMS_FLG_EQZ    0
`define DMS_FLG_EQZM   1
`define DMS_FLG_EQOM   2
`define DMS_FLG_EQPAT  3
`define DMS_FLG_EQPATB 4
`define DMS_FLG_OVER   5
`define DMS_FLG_UNDER  6
`define DMS_FLG_OVUN   7
`endif

// ---- hdl/dms_pkg.sv ----
// Types shared by the arithmetic slice.
package dms_pkg;
	typedef enum logic [2:0] {
		product_only_config            = 3'h0,
		accumulate_config              = 3'h1,
		dual_product_accumulate_config = 3'h2,
		dual_product_addsub_config     = 3'h3,
		two_slice_sum_config           = 3'h4
	} dms_elem_t;
	typedef enum logic [1:0] {
		wid_9x9   = 2'h0,
		wid_18x18 = 2'h1,
		wid_18x36 = 2'h2
	} dms_wid_t;
	typedef enum logic [1:0] {
		z_zero     = 2'h0,
		z_c_port   = 2'h1,
		z_cascade  = 2'h2,
		z_casc_shr = 2'h3
	} dms_csel_t;
	typedef enum logic [3:0] {
		op_element = 4'h0,
		op_add3    = 4'h1,
		op_sub3    = 4'h2,
		op_and     = 4'h3,
		op_or      = 4'h4,
		op_nand    = 4'h5,
		op_nor     = 4'h6,
		op_xor     = 4'h7,
		op_xnor    = 4'h8
	} dms_op_t;
endpackage

// ---- hdl/dms_slice.sv ----
// Multiply-accumulate arithmetic slice with an APB configuration port.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dms_regs.svh"
// Summary of operation
// - One 18x36, two 18x18, four 9x9.
// - Two cascaded slices form 36x36.
// - Accumulator result up to 54 bits.
// - Two 18x18 products accumulate per cycle.
// - ALU opcode chosen each cycle.
// - Three-operand add or subtract.
// - Bitwise AND, OR, NAND, NOR, XOR, XNOR.
// - Eight pattern and overflow flags.
// - Synchronous reset, optional asynchronous behaviour.
// - Fabric steers internal muxes per cycle.
// - Operands load from port or chain.
// - Accumulator adds or subtracts per cycle.
// - Parallel or serial operand load per cycle.
// - Product only, optional stage registers.
// - Accumulate with output register forced on.
// - Accumulator initialised dynamically, registered overflow.
// - Both products added to accumulator.
// - Product A plus or minus product B.
// - Second slice sums both add results.
// - Adder trees through cascade and Z mux.
// - Multiplier bypass gives 54-bit adder.
// - Each stage picks qualifier, enable, reset.
module dms_slice
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [17:0]      port_a_operand_x,
	input  wire logic [17:0]      port_a_operand_y,
	input  wire logic [17:0]      port_b_operand_x,
	input  wire logic [17:0]      port_b_operand_y,
	input  wire logic [53:0]      c_operand,
	input  wire logic [71:0]      operand_chain_in,
	output logic      [71:0]      operand_chain_out,
	input  wire logic [53:0]      cascade_in_bus,
	output logic      [53:0]      cascade_out_bus,
	input  wire dms_pkg::dms_op_t alu_op,
	input  wire logic             add_sub,
	input  wire logic             shift_load,
	input  wire logic             acc_load,
	input  wire logic [3:0]       stage_tick,
	input  wire logic [3:0]       stage_ce,
	input  wire logic [3:0]       stage_rst,
	output logic      [71:0]      product_out,
	output logic      [53:0]      result_out,
	output logic      [7:0]       flags_out,
	output logic                  overflow_out
);
	import dms_pkg::*;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Picks one of four fabric control lines.
	function automatic logic pick(input logic [3:0] v, input logic [1:0] s);
		pick = v[s];
	endfunction

	// Multiplies two extended operands, signed when asked.
	function automatic logic [71:0] smul(input logic [35:0] x, input logic [35:0] y,
		input logic s);
		logic signed [36:0] xs;
		logic signed [36:0] ys;
		xs = {s & x[35], x};
		ys = {s & y[35], y};
		smul = 72'(xs * ys);
	endfunction

	// Extends a 54-bit value to the 56-bit adder width.
	function automatic logic [55:0] x56(input logic [53:0] v, input logic s);
		x56 = {{2{s & v[53]}}, v};
	endfunction

	// Matches an APB address against a register offset.
	function automatic logic is_at(input logic [11:0] a, input logic [11:0] o);
		is_at = (a == o);
	endfunction

	// ------------------------------------------------------------
	// APB configuration registers
	// ------------------------------------------------------------
	logic [17:0] cfg_reg;
	logic [31:0] pat_reg;
	logic [31:0] mask_reg;
	logic [53:0] out_reg;
	logic [71:0] lanes_reg;
	logic [7:0]  flag_reg;

	wire logic hit = is_at(paddr, `DMS_OFS_CFG) || is_at(paddr, `DMS_OFS_PAT)
		|| is_at(paddr, `DMS_OFS_MASK) || is_at(paddr, `DMS_OFS_STAT)
		|| is_at(paddr, `DMS_OFS_RESLO) || is_at(paddr, `DMS_OFS_RESHI);
	wire logic wr_en = psel && penable && pwrite && hit;

	// Zero wait states; unmapped addresses answer with an error.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	// Configuration and pattern registers take writes in the access phase.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			cfg_reg  <= `DMS_CFG_RST;
			pat_reg  <= `DMS_PAT_RST;
			mask_reg <= `DMS_MASK_RST;
		end
		else if (wr_en)
		begin
			if (is_at(paddr, `DMS_OFS_CFG))
				cfg_reg <= pwdata[17:0];
			if (is_at(paddr, `DMS_OFS_PAT))
				pat_reg <= pwdata;
			if (is_at(paddr, `DMS_OFS_MASK))
				mask_reg <= pwdata;
		end
	end

	// Configuration fields.
	wire dms_elem_t elem   = dms_elem_t'(cfg_reg[`DMS_CFG_ELEM]);
	wire dms_wid_t  wid    = dms_wid_t'(cfg_reg[`DMS_CFG_WID]);
	wire dms_csel_t csel   = dms_csel_t'(cfg_reg[`DMS_CFG_CSEL]);
	wire logic      sg     = cfg_reg[`DMS_CFG_SGN];
	wire logic      async  = cfg_reg[`DMS_CFG_ASYNC];
	wire logic      accum  = (elem == accumulate_config)
		|| (elem == dual_product_accumulate_config);
	wire logic      in_on  = cfg_reg[`DMS_CFG_INREG];
	wire logic      pp_on  = cfg_reg[`DMS_CFG_PPREG];
	wire logic      out_on = cfg_reg[`DMS_CFG_OUTREG] || accum;

	// ------------------------------------------------------------
	// Stage clocking controls
	// ------------------------------------------------------------
	// Per-stage qualifier select.
	wire logic en_in  = pick(stage_tick, cfg_reg[`DMS_CFG_SELIN])
		&& pick(stage_ce, cfg_reg[`DMS_CFG_SELIN]);
	wire logic rs_in  = pick(stage_rst, cfg_reg[`DMS_CFG_SELIN]);
	wire logic en_pp  = pick(stage_tick, cfg_reg[`DMS_CFG_SELPP])
		&& pick(stage_ce, cfg_reg[`DMS_CFG_SELPP]);
	wire logic rs_pp  = pick(stage_rst, cfg_reg[`DMS_CFG_SELPP]);
	wire logic en_out = pick(stage_tick, cfg_reg[`DMS_CFG_SELOUT])
		&& pick(stage_ce, cfg_reg[`DMS_CFG_SELOUT]);
	wire logic rs_out = pick(stage_rst, cfg_reg[`DMS_CFG_SELOUT]);

	// ------------------------------------------------------------
	// Input operand stage
	// ------------------------------------------------------------
	logic [71:0] opr_reg;

	wire logic [71:0] opr_next = shift_load ? operand_chain_in
		: {port_a_operand_x, port_a_operand_y, port_b_operand_x, port_b_operand_y};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || rs_in)
			opr_reg <= 72'h0;
		else if (en_in)
			opr_reg <= opr_next;
	end

	wire logic [71:0] opr_use = !in_on ? opr_next : (async && rs_in) ? 72'h0 : opr_reg;

	// Operand register feeds the next slice in the chain.
	assign operand_chain_out = opr_reg;

	wire logic [17:0] ax = opr_use[71:54];
	wire logic [17:0] ay = opr_use[53:36];
	wire logic [17:0] bx = opr_use[35:18];
	wire logic [17:0] by = opr_use[17:0];

	// ------------------------------------------------------------
	// Multipliers
	// ------------------------------------------------------------
	logic [71:0] p9;
	wire logic [35:0] xcat = {bx, ax};
	wire logic [35:0] ycat = {by, ay};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			wire logic [8:0]  xv = xcat[9*gi +: 9];
			wire logic [8:0]  yv = ycat[9*gi +: 9];
			wire logic [71:0] pv = smul({{27{sg & xv[8]}}, xv}, {{27{sg & yv[8]}}, yv}, sg);
			assign p9[18*gi +: 18] = pv[17:0];
		end
	endgenerate

	wire logic [71:0] m_a18 = smul({{18{sg & ax[17]}}, ax}, {{18{sg & ay[17]}}, ay}, sg);
	wire logic [71:0] m_b18 = smul({{18{sg & bx[17]}}, bx}, {{18{sg & by[17]}}, by}, sg);
	wire logic [71:0] m_a36 = smul({{18{sg & ax[17]}}, ax}, {ay, by}, sg);

	// Products handed to the ALU and the product-only lanes.
	wire logic [53:0] pa = (wid == wid_9x9) ? {{36{sg & p9[17]}}, p9[17:0]}
		: (wid == wid_18x18) ? {{18{sg & m_a18[35]}}, m_a18[35:0]} : m_a36[53:0];
	wire logic [53:0] pb = (wid == wid_9x9) ? {{36{sg & p9[53]}}, p9[53:36]}
		: (wid == wid_18x18) ? {{18{sg & m_b18[35]}}, m_b18[35:0]} : 54'h0;
	wire logic [71:0] lanes = (wid == wid_9x9) ? p9
		: (wid == wid_18x18) ? {m_b18[35:0], m_a18[35:0]} : {18'h0, m_a36[53:0]};
	wire logic [53:0] bp = opr_use[71:18];

	// ------------------------------------------------------------
	// Pipeline stage
	// ------------------------------------------------------------
	logic [233:0] pp_reg;
	wire logic [233:0] pp_next = {lanes, pa, pb, bp};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || rs_pp)
			pp_reg <= 234'h0;
		else if (en_pp)
			pp_reg <= pp_next;
	end

	wire logic [233:0] pp_use = !pp_on ? pp_next : (async && rs_pp) ? 234'h0 : pp_reg;
	wire logic [71:0]  lanes_u = pp_use[233:162];
	wire logic [53:0]  pa_u    = pp_use[161:108];
	wire logic [53:0]  pb_u    = pp_use[107:54];
	wire logic [53:0]  bp_u    = pp_use[53:0];

	// ------------------------------------------------------------
	// ALU
	// ------------------------------------------------------------
	// Third-operand mux.
	wire logic [53:0] zv = (csel == z_c_port) ? c_operand
		: (csel == z_cascade) ? cascade_in_bus
		: (csel == z_casc_shr) ? {{18{sg & cascade_in_bus[53]}}, cascade_in_bus[53:18]}
		: 54'h0;

	wire logic [53:0] base = acc_load ? zv : out_reg;

	wire logic [55:0] sa = add_sub ? 56'(-x56(pa_u, sg)) : x56(pa_u, sg);
	wire logic [55:0] sb = add_sub ? 56'(-x56(pb_u, sg)) : x56(pb_u, sg);

	wire logic [55:0] s_acc  = 56'(x56(base, sg) + sa);
	wire logic [55:0] s_dacc = 56'(x56(base, sg) + x56(pa_u, sg) + sb);
	wire logic [55:0] s_dadd = 56'(x56(pa_u, sg) + sb);
	wire logic [55:0] s_sum  = 56'(s_dadd + x56(zv, sg));

	wire logic [55:0] arith = (elem == accumulate_config) ? s_acc
		: (elem == dual_product_accumulate_config) ? s_dacc
		: (elem == dual_product_addsub_config) ? s_dadd
		: (elem == two_slice_sum_config) ? s_sum : x56(pa_u, sg);

	wire logic [55:0] s_add3 = 56'(x56(bp_u, sg) + x56(base, sg) + x56(zv, sg));
	wire logic [55:0] s_sub3 = 56'(x56(bp_u, sg) - x56(base, sg) - x56(zv, sg));

	wire logic [55:0] alu = (alu_op == op_element) ? arith
		: (alu_op == op_add3) ? s_add3
		: (alu_op == op_sub3) ? s_sub3
		: (alu_op == op_and) ? {2'h0, bp_u & zv}
		: (alu_op == op_or) ? {2'h0, bp_u | zv}
		: (alu_op == op_nand) ? {2'h0, ~(bp_u & zv)}
		: (alu_op == op_nor) ? {2'h0, ~(bp_u | zv)}
		: (alu_op == op_xor) ? {2'h0, bp_u ^ zv}
		: (alu_op == op_xnor) ? {2'h0, ~(bp_u ^ zv)} : 56'h0;

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	wire logic       is_ar = (alu_op == op_element) || (alu_op == op_add3)
		|| (alu_op == op_sub3);
	// Dual accumulation flags overflow beyond a 52-bit range.
	wire logic [3:0] hi = (elem == dual_product_accumulate_config) ? alu[54:51]
		: {alu[54], alu[54], alu[54:53]};
	wire logic       ovf_n = is_ar && !alu[55] && (sg ? (|hi) : (|hi[3:1])); // Unsigned keeps MSB.
	wire logic       unf_n = is_ar && alu[55] && (sg ? !(&hi) : 1'b1);
	wire logic [31:0] rl = alu[31:0];

	wire logic [7:0] flag_next = {ovf_n || unf_n, unf_n, ovf_n,
		((rl ^ ~pat_reg) & ~mask_reg) == 32'h0,
		((rl ^ pat_reg) & ~mask_reg) == 32'h0,
		(rl | mask_reg) == 32'hffff_ffff,
		(rl & ~mask_reg) == 32'h0,
		alu[53:0] == 54'h0};

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	// Output register holds accumulation.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || rs_out)
		begin
			out_reg   <= 54'h0;
			lanes_reg <= 72'h0;
			flag_reg  <= 8'h0;
		end
		else if (en_out && out_on)
		begin
			out_reg   <= alu[53:0];
			lanes_reg <= lanes_u;
			flag_reg  <= flag_next;
		end
	end

	wire logic oz = async && rs_out;

	assign result_out      = !out_on ? alu[53:0] : oz ? 54'h0 : out_reg;
	assign product_out     = !out_on ? lanes_u : oz ? 72'h0 : lanes_reg;
	assign flags_out       = !out_on ? flag_next : oz ? 8'h0 : flag_reg;
	assign overflow_out    = flags_out[`DMS_FLG_OVER];
	assign cascade_out_bus = result_out;

	// Read data mux.
	assign prdata = !psel ? 32'h0
		: is_at(paddr, `DMS_OFS_CFG) ? {14'h0, cfg_reg}
		: is_at(paddr, `DMS_OFS_PAT) ? pat_reg
		: is_at(paddr, `DMS_OFS_MASK) ? mask_reg
		: is_at(paddr, `DMS_OFS_STAT) ? {24'h0, flags_out}
		: is_at(paddr, `DMS_OFS_RESLO) ? result_out[31:0]
		: is_at(paddr, `DMS_OFS_RESHI) ? {10'h0, result_out[53:32]} : 32'h0;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_in_load;
		en_in && !rs_in;
	endsequence
	sequence s_out_load;
		en_out && !rs_out && out_on;
	endsequence

	a_chain_shift: assert property (s_in_load ##0 shift_load |=>
		opr_reg == $past(operand_chain_in)) else $error("chain shift lost");
	a_stage_clear: assert property (rs_in |=> opr_reg == 72'h0)
		else $error("input stage not cleared");
	a_acc_step: assert property (elem == accumulate_config && alu_op == op_element
		&& !acc_load ##0 s_out_load |=> out_reg == ($past(add_sub)
		? 54'($past(out_reg) - $past(pa_u)) : 54'($past(out_reg) + $past(pa_u))))
		else $error("accumulate step wrong");
	a_dual_acc: assert property (elem == dual_product_accumulate_config && !add_sub
		&& alu_op == op_element && !acc_load ##0 s_out_load |=> out_reg ==
		54'($past(out_reg) + $past(pa_u) + $past(pb_u))) else $error("dual accumulate wrong");
	a_prod_18: assert property (wid == wid_18x18 && !sg |->
		m_a18[35:0] == 36'(ax * ay)) else $error("18x18 product wrong");
	a_logic_xor: assert property (alu_op == op_xor ##0 s_out_load |=>
		out_reg == $past(bp_u ^ zv)) else $error("xor result wrong");
	a_ovf_reg: assert property (s_out_load ##0 ovf_n |=>
		flag_reg[`DMS_FLG_OVER] && flag_reg[`DMS_FLG_OVUN]) else $error("overflow not held");
	a_casc_sum: assert property (elem == two_slice_sum_config && csel == z_cascade
		&& alu_op == op_element && !add_sub ##0 s_out_load |=> out_reg ==
		54'($past(pa_u) + $past(pb_u) + $past(cascade_in_bus))) else $error("sum wrong");
endmodule
`default_nettype wire

// ---- bench/dms_fabric_model.sv ----
// Fabric-side model that feeds the slice's chain, cascade and stage strobes.
`timescale 1ns/1ps
`default_nettype none
module dms_fabric_model
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [71:0] prev_ops,
	input  wire logic [53:0] prev_res,
	output logic      [71:0] operand_chain_in,
	output logic      [53:0] cascade_in_bus,
	output logic      [3:0]  stage_tick
);
	logic phase_reg;

	// ----------------------------------------------------------------
	// Upstream slice registers
	// ----------------------------------------------------------------
	// The preceding slice holds its operand word and its result in registers.
	// Upstream operand and result.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			operand_chain_in <= '0;
			cascade_in_bus   <= '0;
			phase_reg        <= 1'b0;
		end
		else
		begin
			operand_chain_in <= prev_ops;
			cascade_in_bus   <= prev_res;
			phase_reg        <= ~phase_reg;
		end
	end

	// Line zero ticks every cycle; the other lines tick on alternate cycles.
	// Four stage strobes.
	assign stage_tick = {~phase_reg, phase_reg, phase_reg, 1'b1};
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the multiply-accumulate slice.
`timescale 1ns/1ps
`default_nettype none
`include "dms_regs.svh"
module tb;
	import dms_pkg::*;
	logic            ref_clk = 1'b0;
	logic            rst_b = 1'b0;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic            add_sub = 1'b0;
	logic            shift_load = 1'b0;
	logic            acc_load = 1'b0;
	logic            pready, pslverr, overflow_out, err;
	logic     [11:0] paddr = 12'h000;
	logic     [31:0] pwdata = 32'h0, prdata, rd;
	logic     [17:0] ax = 18'h00a07, ay = 18'h0160d, bx = 18'h00602, by = 18'h02213;
	logic      [3:0] stage_tick;
	logic      [3:0] stage_ce = 4'hf;
	logic      [3:0] stage_rst = 4'h0;
	logic      [7:0] flags_out;
	logic     [35:0] pa, pb;
	logic     [53:0] c_operand = 54'h0, e, prev_res = 54'h2b_1357_9bdf_0246;
	logic     [53:0] cascade_in_bus, cascade_out_bus, result_out;
	logic     [71:0] prev_ops = 72'h9a_bcde_f012_3456_789a, keep;
	logic     [71:0] operand_chain_in, operand_chain_out, product_out;
	dms_op_t         alu_op = op_element;
	int              bad_count = 0, samples_checked = 0, cycles = 0;

	dms_slice dut
	(
		.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .port_a_operand_x (ax), .port_a_operand_y (ay), .port_b_operand_x (bx),
		.port_b_operand_y (by), .c_operand, .operand_chain_in, .operand_chain_out,
		.cascade_in_bus, .cascade_out_bus, .alu_op, .add_sub, .shift_load, .acc_load,
		.stage_tick, .stage_ce, .stage_rst, .product_out, .result_out, .flags_out,
		.overflow_out
	);

	dms_fabric_model fab
	(
		.ref_clk, .rst_b, .prev_ops, .prev_res, .operand_chain_in, .cascade_in_bus,
		.stage_tick
	);

	// ----------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ----------------------------------------------------------------
	// Free-running reference clock.
	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end

	// A run that outlives its budget is cut short and fails.
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			conclude;
		end
	end

	task automatic chk(input string nm, input logic [71:0] x, input logic [71:0] g);
		samples_checked++;
		if (g !== x)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] cfgw(input logic [2:0] el, input logic [1:0] wd,
		input logic sg, input logic [2:0] rg, input logic [1:0] cs);
		return {20'h0, cs, 1'b0, rg, sg, wd, el};
	endfunction

	task automatic prods;
		pa = ax * ay;
		pb = bx * by;
	endtask

	task automatic conclude;
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, `DMS_OFS_CFG, 32'h0);
		chk("cfg reset", 32'(`DMS_CFG_RST), rd);
		apb(1'b1, `DMS_OFS_PAT, 32'h5a5a_0f0f);
		apb(1'b0, `DMS_OFS_PAT, 32'h0);
		chk("pattern", 32'h5a5a_0f0f, rd);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped error", 1'b1, err);
	endtask

	// Products through all three stages, for every width unsigned and for signed 18x18.
	task automatic t_product_only_config;
		logic [17:0] q [4];
		logic [53:0] pl;
		for (int w = 0; w < 3; w++)
		begin
			apb(1'b1, `DMS_OFS_CFG, cfgw(3'h0, 2'(w), 1'b0, 3'h7, 2'h0));
			repeat (3) @(posedge ref_clk);
			#1;
			prods;
			q[0] = ax[8:0] * ay[8:0];
			q[1] = ax[17:9] * ay[17:9];
			q[2] = bx[8:0] * by[8:0];
			q[3] = bx[17:9] * by[17:9];
			pl = ax * {ay, by};
			if (w == 0)
				chk("lanes 9x9", {q[3], q[2], q[1], q[0]}, product_out);
			if (w == 1)
				chk("pair 18x18", {pb, pa}, product_out);
			if (w == 2)
				chk("wide 18x36", {18'h0, pl}, {18'h0, product_out[53:0]});
		end
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h0, 2'h1, 1'b1, 3'h7, 2'h0));
		ax <= 18'h3fffd;
		repeat (3) @(posedge ref_clk);
		#1;
		pa = $signed(ax) * $signed(ay);
		chk("signed 18x18", {36'h0, pa}, {36'h0, product_out[35:0]});
	endtask

	// Accumulator seeded from the third operand, then adding and subtracting.
	task automatic t_acc;
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h1, 2'h1, 1'b0, 3'h4, 2'h1));
		ax <= 18'h30000;
		ay <= 18'h30000;
		c_operand <= 54'h00_0100_0000_0001;
		acc_load <= 1'b1;
		@(posedge ref_clk);
		acc_load <= 1'b0;
		#1;
		prods;
		chk("acc init", c_operand + pa, result_out);
		@(posedge ref_clk);
		add_sub <= 1'b1;
		#1;
		chk("acc add", c_operand + 2 * pa, result_out);
		@(posedge ref_clk);
		add_sub <= 1'b0;
		#1;
		chk("acc subtract", c_operand + pa, result_out);
		chk("acc overflow", 1'b0, overflow_out);
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h2, 2'h1, 1'b0, 3'h4, 2'h1));
		acc_load <= 1'b1;
		@(posedge ref_clk);
		acc_load <= 1'b0;
		#1;
		chk("dual acc", c_operand + pa + pb, result_out);
		@(posedge ref_clk);
		#1;
		chk("dual acc again", c_operand + 2 * (pa + pb), result_out);
		// A seed above the 52-bit dual range must raise the held overflow.
		@(posedge ref_clk);
		c_operand <= 54'h10_0000_0000_0000;
		acc_load <= 1'b1;
		@(posedge ref_clk);
		acc_load <= 1'b0;
		#1;
		chk("dual acc seed", 54'h10_0000_0000_0000 + pa + pb, result_out);
		chk("dual acc overflow", 1'b1, overflow_out);
	endtask

	// Every ALU opcode unregistered, then the add/subtract and cascade sums.
	task automatic t_alu;
		logic [53:0] z, bp;
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h0, 2'h1, 1'b0, 3'h0, 2'h1));
		c_operand <= 54'h2a_5a5a_c3c3_0f0f;
		acc_load <= 1'b1;
		for (int k = 1; k < 9; k++)
		begin
			@(posedge ref_clk);
			alu_op <= dms_op_t'(k);
			#1;
			z = c_operand;
			bp = {ax, ay, bx};
			case (k)
				1: e = bp + z + z;
				2: e = bp - z - z;
				3: e = bp & z;
				4: e = bp | z;
				5: e = ~(bp & z);
				6: e = ~(bp | z);
				7: e = bp ^ z;
				default: e = bp ~^ z;
			endcase
			chk("alu op", e, result_out);
		end
		@(posedge ref_clk);
		c_operand <= 54'h0;
		alu_op <= op_and;
		#1;
		chk("zero flag", 1'b1, flags_out[0]);
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h3, 2'h1, 1'b0, 3'h0, 2'h0));
		alu_op <= op_element;
		#1;
		prods;
		chk("sum of products", pa + pb, result_out);
		@(posedge ref_clk);
		add_sub <= 1'b1;
		#1;
		chk("difference of products", pa - pb, result_out);
		// The two-slice sum runs through the output register.
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h4, 2'h1, 1'b0, 3'h4, 2'h2));
		add_sub <= 1'b0;
		@(posedge ref_clk);
		#1;
		e = pa + pb + prev_res;
		chk("two-slice sum", e, result_out);
		chk("cascade out", e, cascade_out_bus);
	endtask

	// Serial then parallel operand loads, a stalled stage and a stage clear.
	task automatic t_chain;
		// Bit 9 selects the asynchronous stage clear; XOR keeps the output stage busy.
		apb(1'b1, `DMS_OFS_CFG, cfgw(3'h0, 2'h1, 1'b0, 3'h7, 2'h0) | 32'h0000_0200);
		shift_load <= 1'b1;
		alu_op <= op_xor;
		@(posedge ref_clk);
		shift_load <= 1'b0;
		#1;
		chk("chain shift", prev_ops, operand_chain_out);
		@(posedge ref_clk);
		keep = {ax, ay, bx, by};
		stage_ce <= 4'h0;
		ax <= 18'h00001;
		#1;
		chk("parallel load", keep, operand_chain_out);
		repeat (3) @(posedge ref_clk);
		stage_rst <= 4'h1;
		stage_ce <= 4'hf;
		#1;
		chk("stage hold", keep, operand_chain_out);
		chk("async clear", 54'h0, result_out);
		@(posedge ref_clk);
		stage_rst <= 4'h0;
		#1;
		chk("stage clear", 72'h0, operand_chain_out);
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs;
		t_product_only_config;
		t_acc;
		t_alu;
		t_chain;
		conclude;
	end
endmodule
`default_nettype wire
